// ### rtl/fid_defines.svh
// Constants of the flash identification and reset command block.
// Assumes inclusion by bare name from the top module.
//
// Operation
// [RULE_01] Clear-error opcode 82h zeroes protection, program and erase fail flags.
// [RULE_02] Each error flag, once set, stays set until the clear-error command.
// [RULE_03] Legacy ident read ABh takes three dummy bytes on rising edges.
// [RULE_04] Then the 8-bit device code shifts out MSB first, repeating.
// [RULE_05] 9Fh single-line or AFh quad mode sends maker code then two-byte code.
// [RULE_06] The three-byte standard ident sequence loops while select stays low.
// [RULE_07] Host sends two dummy bytes and one address byte after 90h.
// [RULE_08] Address bit 0 picks maker-first or device-first, then alternating.
// [RULE_09] Unique number read 4Bh takes three address bytes and dummy cycles.
// [RULE_10] The sixteen unique bytes repeat while select is low and clock runs.
// [RULE_11] Param table read 5Ah takes three address bytes, eight dummies, then data.
// [RULE_12] Param table read is refused in quad-command mode.
// [RULE_13] Param addresses outside the tables return unguaranteed data.
// [RULE_14] Opcode 00h only cancels a pending reset arm.
// [RULE_15] Host sends 66h in one frame and 99h in the next frame.
// [RULE_16] Any other command after reset arm disarms it.
// [RULE_17] Software reset reloads volatile state except freeze and lock bits.
// [RULE_18] Shared reset pin works only single-line with quad enable zero.
// [RULE_19] Reset low at least 100ns aborts work and tri-states output.
// [RULE_20] Host waits at least 35us after hardware reset before commands.
// [RULE_21] Reset during program or erase aborts that operation.
// [RULE_22] After wake by ABh select must stay high for the wake recovery time.
// [RULE_23] A frame ending before a whole opcode leaves output idle, no action.
`ifndef FID_DEFINES_SVH
`define FID_DEFINES_SVH

// ---------------------------------------------------------------------------
// Opcodes
// ---------------------------------------------------------------------------
`define FID_OP_CLR_ERR   8'h82
`define FID_OP_LEGACY_ID 8'hAB
`define FID_OP_STD_ID    8'h9F
`define FID_OP_STD_ID_Q  8'hAF
`define FID_OP_MAKER_DEV 8'h90
`define FID_OP_UNIQUE    8'h4B
`define FID_OP_PARAM     8'h5A
`define FID_OP_NOP       8'h00
`define FID_OP_RST_ARM   8'h66
`define FID_OP_RST       8'h99

// ---------------------------------------------------------------------------
// Frame lengths in serial clocks after the opcode
// ---------------------------------------------------------------------------
`define FID_LEN_LEGACY   8'd24
`define FID_LEN_MAKER    8'd24
`define FID_LEN_ADDR     8'd24
`define FID_DUMMY_DEF    8'd8

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define FID_CLK_NS       10
`define FID_HW_RST_NS    100
`define FID_HW_RST_CYC   ((`FID_HW_RST_NS + `FID_CLK_NS - 1) / `FID_CLK_NS)
`define FID_RECOV_US     35
`define FID_RECOV_CYC    (`FID_RECOV_US * 1000 / `FID_CLK_NS)

`endif

// ### rtl/fid_pkg.sv
// Types of the flash identification and reset command block.
// Assumes the constants header is on the include path.
package fid_pkg;

  // -------------------------------------------------------------------------
  // Link-side command phases
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    FID_OPC,
    FID_HDR,
    FID_DATA,
    FID_IGNORE
  } fid_phase_t;

  typedef enum logic [2:0] {
    FID_SRC_NONE,
    FID_SRC_LEGACY,
    FID_SRC_STD,
    FID_SRC_MAKER,
    FID_SRC_UNIQUE,
    FID_SRC_PARAM
  } fid_src_t;

  // Link-domain state on the rising serial clock.
  typedef struct packed {
    fid_phase_t  phase;
    fid_src_t    src;
    logic [7:0]  sh;
    logic [7:0]  cnt;
    logic [7:0]  hdr_len;
    logic [7:0]  addr_lo;
    logic [7:0]  bit_idx;
    logic        clr_tgl;
    logic        arm_tgl;
    logic        disarm_tgl;
    logic        rst_tgl;
  } fid_link_t;

  // Core-domain state on clk.
  typedef struct packed {
    logic [2:0]  sy_clr;
    logic [2:0]  sy_arm;
    logic [2:0]  sy_dis;
    logic [2:0]  sy_rst;
    logic [1:0]  sy_pin;
    logic        armed;
    logic        prot_err;
    logic        prog_err;
    logic        erase_err;
    logic        reload;
    logic        abort;
    logic [7:0]  low_cnt;
    logic [15:0] recov_cnt;
    logic        busy_recov;
  } fid_core_t;

endpackage

// ### rtl/fid_top.sv
// Identification, error-clear and reset command handling of a serial flash.
// Assumes the host drives sclk only while cs_b is low, mode 0, single line.
`timescale 1ns/1ps
`default_nettype none
`include "fid_defines.svh"

module fid_top #(
  parameter int unsigned RECOV_CYC = `FID_RECOV_CYC
) (
  input  wire logic        clk,             // Core clock, 100 MHz.
  input  wire logic        rst_b,           // Synchronous reset, active low.
  input  wire logic        sclk,            // Serial clock from the host.
  input  wire logic        cs_b,            // Chip select, active low.
  input  wire logic        si,              // Serial data in.
  output logic             so,              // Serial data out.
  output logic             so_oe,           // Output enable for so.
  input  wire logic        quad_command_mode, // Quad-command mode active.
  input  wire logic        quad_enable_bit, // Quad enable status bit.
  input  wire logic        pin_function_select_bit, // High selects reset on shared pin.
  input  wire logic        dedicated_reset_en, // Dedicated reset pin is enabled.
  input  wire logic        hw_reset_b,      // Hardware reset pin, active low.
  input  wire logic        prot_fail_set,   // Pulse: protection failure seen.
  input  wire logic        prog_fail_set,   // Pulse: program failure seen.
  input  wire logic        erase_fail_set,  // Pulse: erase failure seen.
  input  wire logic [7:0]  maker_code,      // Manufacturer code.
  input  wire logic [7:0]  device_code,     // Legacy device code.
  input  wire logic [15:0] type_cap_code,   // Memory type and capacity code.
  input  wire logic [127:0] unique_number,  // Factory unique number, byte 0 high.
  input  wire logic [7:0]  param_data,      // Param table byte at param_addr.
  output logic [7:0]       param_addr,      // Param table byte address.
  output logic             protection_fail_flag, // Sticky protection failure.
  output logic             program_fail_flag, // Sticky program failure.
  output logic             erase_fail_flag, // Sticky erase failure.
  output logic             reset_armed,     // Reset arm pending.
  output logic             soft_reload,     // Pulse: reload volatile state.
  output logic             op_abort,        // Pulse: abort program or erase.
  output logic             recovering       // Reset recovery in progress.
);

  // -------------------------------------------------------------------------
  // Link domain: command decode on rising sclk
  // -------------------------------------------------------------------------
  fid_pkg::fid_link_t lk;
  fid_pkg::fid_link_t lk_q;
  fid_pkg::fid_link_t next_lk;
  logic [7:0]         opc;
  logic [7:0]         out_byte;
  logic               out_bit;
  logic               out_bit_q;
  logic               out_en_q;

  assign opc = {lk.sh[6:0], si};

  // Selects the byte that the current data position points at.
  always_comb begin
    out_byte = 8'h00;
    unique case (lk.src)
      fid_pkg::FID_SRC_LEGACY: out_byte = device_code; // [RULE_04]
      fid_pkg::FID_SRC_STD: begin
        // Three-byte cycle loops while select stays low. [RULE_05] [RULE_06]
        unique case (lk.bit_idx[4:3])
          2'd0:    out_byte = maker_code;
          2'd1:    out_byte = type_cap_code[15:8];
          default: out_byte = type_cap_code[7:0];
        endcase
      end
      fid_pkg::FID_SRC_MAKER: // [RULE_08]
        out_byte = (lk.bit_idx[3] ^ lk.addr_lo[0]) ? device_code : maker_code;
      fid_pkg::FID_SRC_UNIQUE: // [RULE_10]
        out_byte = unique_number[8'd127 - {lk.bit_idx[6:3], 3'b000} -: 8];
      fid_pkg::FID_SRC_PARAM: out_byte = param_data; // [RULE_13]
      default: out_byte = 8'h00;
    endcase
    out_bit = out_byte[3'd7 - lk.bit_idx[2:0]];
  end

  // Byte address for the param table, counted from the sent address.
  always_comb begin
    param_addr = lk.addr_lo + {3'b000, lk.bit_idx[7:3]};
  end

  // Decodes the opcode and walks header and data phases.
  always_comb begin
    next_lk = lk;
    next_lk.sh = opc;
    unique case (lk.phase)
      fid_pkg::FID_OPC: begin
        next_lk.cnt = lk.cnt + 8'd1;
        if (lk.cnt == 8'd7) begin
          next_lk.cnt   = 8'd0;
          next_lk.phase = fid_pkg::FID_HDR;
          next_lk.src   = fid_pkg::FID_SRC_NONE;
          // Any whole opcode other than the reset arm and the reset itself disarms. [RULE_16]
          if (opc != `FID_OP_RST && opc != `FID_OP_RST_ARM) begin
            next_lk.disarm_tgl = ~lk.disarm_tgl; // [RULE_14]
          end
          unique case (opc)
            `FID_OP_CLR_ERR: begin
              next_lk.clr_tgl = ~lk.clr_tgl; // [RULE_01]
              next_lk.phase   = fid_pkg::FID_IGNORE;
            end
            `FID_OP_LEGACY_ID: begin
              // No power-down state lives here, so ABh opens no wake window. [RULE_22]
              next_lk.src     = fid_pkg::FID_SRC_LEGACY;
              next_lk.hdr_len = `FID_LEN_LEGACY; // [RULE_03]
            end
            `FID_OP_STD_ID, `FID_OP_STD_ID_Q: begin
              // Each opcode only counts in its own command mode. [RULE_05]
              if ((opc == `FID_OP_STD_ID) != quad_command_mode) begin
                next_lk.src   = fid_pkg::FID_SRC_STD;
                next_lk.phase = fid_pkg::FID_DATA;
              end else begin
                next_lk.phase = fid_pkg::FID_IGNORE;
              end
            end
            `FID_OP_MAKER_DEV: begin
              next_lk.src     = fid_pkg::FID_SRC_MAKER;
              next_lk.hdr_len = `FID_LEN_MAKER; // [RULE_07]
            end
            `FID_OP_UNIQUE: begin
              next_lk.src     = fid_pkg::FID_SRC_UNIQUE;
              next_lk.hdr_len = `FID_LEN_ADDR + `FID_DUMMY_DEF; // [RULE_09]
            end
            `FID_OP_PARAM: begin
              if (quad_command_mode) begin
                next_lk.phase = fid_pkg::FID_IGNORE; // [RULE_12]
              end else begin
                next_lk.src     = fid_pkg::FID_SRC_PARAM;
                next_lk.hdr_len = `FID_LEN_ADDR + `FID_DUMMY_DEF; // [RULE_11]
              end
            end
            `FID_OP_RST_ARM: begin
              next_lk.arm_tgl = ~lk.arm_tgl;
              next_lk.phase   = fid_pkg::FID_IGNORE;
            end
            `FID_OP_RST: begin
              next_lk.rst_tgl = ~lk.rst_tgl; // [RULE_17]
              next_lk.phase   = fid_pkg::FID_IGNORE;
            end
            default: next_lk.phase = fid_pkg::FID_IGNORE;
          endcase
        end
      end
      fid_pkg::FID_HDR: begin
        next_lk.cnt = lk.cnt + 8'd1;
        // The third header byte is the low address byte for 90h, 4Bh, 5Ah.
        if (lk.cnt == 8'd23) begin
          next_lk.addr_lo = opc;
        end
        if (next_lk.cnt == lk.hdr_len) begin
          next_lk.phase = fid_pkg::FID_DATA;
        end
      end
      fid_pkg::FID_DATA: begin
        next_lk.bit_idx = lk.bit_idx + 8'd1;
        if (lk.src == fid_pkg::FID_SRC_STD && lk.bit_idx == 8'd23) begin
          next_lk.bit_idx = 8'd0;
        end
        if (lk.src == fid_pkg::FID_SRC_LEGACY && lk.bit_idx == 8'd7) begin
          next_lk.bit_idx = 8'd0;
        end
        if (lk.src == fid_pkg::FID_SRC_MAKER && lk.bit_idx == 8'd15) begin
          next_lk.bit_idx = 8'd0;
        end
        if (lk.src == fid_pkg::FID_SRC_UNIQUE && lk.bit_idx == 8'd127) begin
          next_lk.bit_idx = 8'd0;
        end
      end
      default: next_lk.phase = fid_pkg::FID_IGNORE;
    endcase
  end

  // Frame state clears asynchronously with select high; toggles must survive,
  // so they sit in a separate always_ff without the select reset.
  // Known start value; the core keeps its toggle synchronisers shifting in reset, so
  // whatever value the toggles hold at start never fires a false event.
  logic [3:0] lk_tgl = 4'h0;
  always_ff @(posedge sclk) begin
    lk_tgl <= {next_lk.clr_tgl, next_lk.arm_tgl, next_lk.disarm_tgl, next_lk.rst_tgl};
  end

  // Partial opcodes die with the frame, so nothing happens. [RULE_23]
  always_ff @(posedge sclk or posedge cs_b) begin
    if (cs_b) begin
      lk_q <= '0;
    end else begin
      lk_q <= next_lk;
    end
  end

  // Frame fields come from the select-cleared flops, toggles from their own.
  always_comb begin
    lk            = lk_q;
    lk.clr_tgl    = lk_tgl[3];
    lk.arm_tgl    = lk_tgl[2];
    lk.disarm_tgl = lk_tgl[1];
    lk.rst_tgl    = lk_tgl[0];
  end

  // Data leaves on the falling edge, half a clock ahead of host sampling.
  always_ff @(negedge sclk or posedge cs_b) begin
    if (cs_b) begin
      out_bit_q <= 1'b0;
      out_en_q  <= 1'b0;
    end else begin
      out_bit_q <= out_bit; // [RULE_04]
      out_en_q  <= (lk.phase == fid_pkg::FID_DATA);
    end
  end

  assign so    = out_bit_q;
  assign so_oe = out_en_q & ~recovering; // [RULE_19]

  // -------------------------------------------------------------------------
  // Core domain: sticky flags, reset arm and reset timing
  // -------------------------------------------------------------------------
  fid_pkg::fid_core_t cr;
  fid_pkg::fid_core_t next_cr;
  logic               clr_ev;
  logic               arm_ev;
  logic               dis_ev;
  logic               rst_ev;
  logic               pin_ok;

  assign clr_ev = cr.sy_clr[2] ^ cr.sy_clr[1];
  assign arm_ev = cr.sy_arm[2] ^ cr.sy_arm[1];
  assign dis_ev = cr.sy_dis[2] ^ cr.sy_dis[1];
  assign rst_ev = cr.sy_rst[2] ^ cr.sy_rst[1];
  // Shared pin only counts single-line with quad enable off. [RULE_18]
  assign pin_ok = dedicated_reset_en |
                  (pin_function_select_bit & ~quad_command_mode & ~quad_enable_bit);

  // Synchronisers, sticky flags and reset sequencing.
  always_comb begin
    next_cr = cr;
    next_cr.sy_clr = {cr.sy_clr[1:0], lk.clr_tgl};
    next_cr.sy_arm = {cr.sy_arm[1:0], lk.arm_tgl};
    next_cr.sy_dis = {cr.sy_dis[1:0], lk.disarm_tgl};
    next_cr.sy_rst = {cr.sy_rst[1:0], lk.rst_tgl};
    next_cr.sy_pin = {cr.sy_pin[0], hw_reset_b};
    next_cr.reload = 1'b0;
    next_cr.abort  = 1'b0;
    // Set beats clear in the same cycle. [RULE_01] [RULE_02]
    if (clr_ev) begin
      next_cr.prot_err  = 1'b0;
      next_cr.prog_err  = 1'b0;
      next_cr.erase_err = 1'b0;
    end
    if (prot_fail_set)  next_cr.prot_err  = 1'b1;
    if (prog_fail_set)  next_cr.prog_err  = 1'b1;
    if (erase_fail_set) next_cr.erase_err = 1'b1;
    if (dis_ev) next_cr.armed = 1'b0; // [RULE_16]
    if (arm_ev) next_cr.armed = 1'b1;
    if (rst_ev && cr.armed) begin
      next_cr.armed  = 1'b0;
      next_cr.reload = 1'b1; // [RULE_17]
      next_cr.abort  = 1'b1; // [RULE_21]
    end
    // Count the low pulse; fire once it reaches the least width. [RULE_19]
    if (!cr.sy_pin[1] && pin_ok) begin
      if (cr.low_cnt != 8'(`FID_HW_RST_CYC)) begin
        next_cr.low_cnt = cr.low_cnt + 8'd1;
      end
      if (cr.low_cnt == 8'(`FID_HW_RST_CYC) - 8'd1) begin
        next_cr.abort      = 1'b1; // [RULE_21]
        next_cr.armed      = 1'b0;
        next_cr.busy_recov = 1'b1;
        next_cr.recov_cnt  = 16'(RECOV_CYC); // [RULE_20]
      end
    end else begin
      next_cr.low_cnt = 8'h00;
      if (cr.busy_recov) begin
        next_cr.recov_cnt = cr.recov_cnt - 16'd1;
        if (cr.recov_cnt == 16'd1) next_cr.busy_recov = 1'b0;
      end
    end
  end

  // The toggle synchronisers keep shifting in reset, so a toggle left from before reset
  // is absorbed rather than seen as a fresh command afterwards.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cr        <= '0;
      cr.sy_clr <= next_cr.sy_clr;
      cr.sy_arm <= next_cr.sy_arm;
      cr.sy_dis <= next_cr.sy_dis;
      cr.sy_rst <= next_cr.sy_rst;
    end else begin
      cr <= next_cr;
    end
  end

  assign protection_fail_flag = cr.prot_err;
  assign program_fail_flag    = cr.prog_err;
  assign erase_fail_flag      = cr.erase_err;
  assign reset_armed          = cr.armed;
  assign soft_reload          = cr.reload;
  assign op_abort             = cr.abort;
  assign recovering           = cr.busy_recov;

endmodule

`default_nettype wire

// ### sim/fid_props.sv
// Concurrent checks on the ports of the identification and reset block.
// Assumes binding into fid_top; all checks run on the core clock.
`timescale 1ns/1ps
`default_nettype none

module fid_props #(
  parameter int unsigned RECOV_CYC = 3500
) (
  input wire logic clk,                     // Core clock.
  input wire logic rst_b,                   // Core reset, active low.
  input wire logic cs_b,                    // Chip select.
  input wire logic so_oe,                   // Output enable.
  input wire logic quad_command_mode,       // Quad mode level.
  input wire logic quad_enable_bit,         // Quad enable level.
  input wire logic pin_function_select_bit, // Shared pin as reset.
  input wire logic dedicated_reset_en,      // Dedicated pin on.
  input wire logic hw_reset_b,              // Hardware reset pin.
  input wire logic prot_fail_set,           // Set pulse.
  input wire logic prog_fail_set,           // Set pulse.
  input wire logic erase_fail_set,          // Set pulse.
  input wire logic protection_fail_flag,    // Sticky flag.
  input wire logic program_fail_flag,       // Sticky flag.
  input wire logic erase_fail_flag,         // Sticky flag.
  input wire logic reset_armed,             // Arm pending.
  input wire logic soft_reload,             // Reload pulse.
  input wire logic op_abort,                // Abort pulse.
  input wire logic recovering               // Recovery level.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // -------------------------------------------------------------------------
  // Recovery length counter
  // -------------------------------------------------------------------------
  // Counts recovering cycles once the pin is seen high again; the wait runs
  // from the end of the pulse, however long the pin stays low.
  logic [15:0] rc;
  logic [1:0]  pin_s;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rc    <= '0;
      pin_s <= '0;
    end else begin
      pin_s <= {pin_s[0], hw_reset_b};
      rc    <= (recovering && pin_s[1]) ? rc + 16'h0001 : 16'h0000;
    end
  end

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  a_prot_sets: assert property (prot_fail_set |=> ##[0:2] protection_fail_flag)
    else $error("protection flag not set");
  a_prog_sets: assert property (prog_fail_set |=> ##[0:2] program_fail_flag)
    else $error("program flag not set");
  a_erase_sets: assert property (erase_fail_set |=> ##[0:2] erase_fail_flag)
    else $error("erase flag not set");
  a_reload_armed: assert property (soft_reload |-> $past(reset_armed) || $past(reset_armed, 2))
    else $error("reload without arm");
  a_reload_disarm: assert property (soft_reload |=> !reset_armed)
    else $error("arm kept after reload");
  a_reload_pulse: assert property (soft_reload |=> !soft_reload)
    else $error("reload longer than one cycle");
  a_abort_on_reset: assert property ((soft_reload || $rose(recovering)) |->
    ($past(op_abort) or ##[0:2] op_abort))
    else $error("reset without abort");
  a_hw_gate_ok: assert property ($rose(recovering) |-> dedicated_reset_en ||
    (pin_function_select_bit && !quad_enable_bit && !quad_command_mode))
    else $error("hardware reset honoured while gated");
  a_recov_len: assert property ($fell(recovering) && $past(rst_b) |-> rc == 16'(RECOV_CYC))
    else $error("recovery window length wrong");
  a_recov_quiet: assert property (recovering |-> !so_oe)
    else $error("output driven while recovering");
  a_idle_quiet: assert property (cs_b && $past(cs_b) && $past(cs_b, 2) |-> !so_oe)
    else $error("output driven while deselected");

  c_reload: cover property (soft_reload);
  c_recov: cover property ($fell(recovering));
  c_clear: cover property ($fell(protection_fail_flag));
endmodule

bind fid_top fid_props #(.RECOV_CYC(RECOV_CYC)) u_props (.clk, .rst_b, .cs_b, .so_oe,
  .quad_command_mode, .quad_enable_bit, .pin_function_select_bit, .dedicated_reset_en, .hw_reset_b,
  .prot_fail_set, .prog_fail_set, .erase_fail_set, .protection_fail_flag,
  .program_fail_flag, .erase_fail_flag, .reset_armed, .soft_reload, .op_abort, .recovering);

`default_nettype wire

// ### sim/fid_host.sv
// Host side of the serial link: mode 0 frames on a 32 ns serial clock.
// Assumes the bench calls xfer and waits between frames.
`timescale 1ns/1ps
`default_nettype none

module fid_host (
  output logic     sclk,  // Serial clock, still outside frames.
  output logic     cs_b,  // Chip select, active low.
  output logic     si,    // Serial data to the device.
  input wire logic so,    // Serial data from the device.
  input wire logic so_oe  // Device output enable.
);
  logic oe_seen;

  initial begin
    sclk = 1'b0;
    cs_b = 1'b0;
    si = 1'b0;
    oe_seen = 1'b0;
    // A clean rising select edge clears the link flops before any frame.
    #1 cs_b = 1'b1;
  end

  // Notes any cycle in which the device drove the data line.
  always @(posedge sclk) begin
    if (so_oe === 1'b1) oe_seen = 1'b1;
  end

  // -------------------------------------------------------------------------
  // One frame: nb bits from v, MSB first, then nr bits read on rising edges
  // -------------------------------------------------------------------------
  // Dummy and address bits are sent in full before any read.
  // Every command gets its own frame and select stays high after.
  task automatic xfer(input logic [63:0] v, input int nb, input int nr, output logic [127:0] rd);
    int i;
    rd = '0;
    oe_seen = 1'b0;
    #3 cs_b = 1'b0;
    for (i = 0; i < nb + nr; i++) begin
      si = (i < nb) ? v[63-i] : ~si;
      #16 sclk = 1'b1;
      if (i >= nb) rd = {rd[126:0], so};
      #16 sclk = 1'b0;
    end
    #16 cs_b = 1'b1;
    si = ~si; // A released line does not keep its last value.
  endtask
endmodule

`default_nettype wire

// ### sim/test_flash_ident_reset_cmds.sv
// Self-checking bench for the identification and reset command block.
// Assumes fid_top, fid_host and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none

module test_flash_ident_reset_cmds;
  localparam logic [7:0] MK = 8'h3C;    // Arbitrary identity value.
  localparam logic [7:0] DEV = 8'hA5;   // Arbitrary identity value.
  localparam logic [15:0] TC = 16'h1E72; // Arbitrary identity value.
  localparam logic [127:0] UID = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [7:0] PK = 8'h5C;

  logic clk = 1'b0, rst_b = 1'b0, hw_reset_b = 1'b1;
  logic quad_command_mode = 1'b0, quad_enable_bit = 1'b0;
  logic pin_function_select_bit = 1'b1, dedicated_reset_en = 1'b0;
  logic prot_fail_set = 1'b0, prog_fail_set = 1'b0, erase_fail_set = 1'b0;
  wire logic sclk, cs_b, si, so, so_oe;
  logic [7:0] param_addr, param_data;
  logic pf, gf, ef, reset_armed, soft_reload, op_abort, recovering;
  logic [127:0] rd;
  int n_fail = 0, compares = 0, n_rl = 0, n_ab = 0, cycles = 0, a;

  // Param table model: each byte is its address mixed with a key.
  assign param_data = param_addr ^ PK;

  fid_top #(.RECOV_CYC(20)) dut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .si(si),
    .so(so), .so_oe(so_oe), .quad_command_mode(quad_command_mode), .quad_enable_bit(quad_enable_bit),
    .pin_function_select_bit(pin_function_select_bit), .dedicated_reset_en(dedicated_reset_en),
    .hw_reset_b(hw_reset_b), .prot_fail_set(prot_fail_set), .prog_fail_set(prog_fail_set),
    .erase_fail_set(erase_fail_set), .maker_code(MK), .device_code(DEV), .type_cap_code(TC),
    .unique_number(UID), .param_data(param_data), .param_addr(param_addr),
    .protection_fail_flag(pf), .program_fail_flag(gf), .erase_fail_flag(ef),
    .reset_armed(reset_armed), .soft_reload(soft_reload), .op_abort(op_abort), .recovering(recovering));

  fid_host h (.sclk(sclk), .cs_b(cs_b), .si(si), .so(so), .so_oe(so_oe));

  always #5 clk = ~clk;

  // Counts reset pulses and cuts a hang short.
  always @(posedge clk) begin
    cycles++;
    if (soft_reload === 1'b1) n_rl++;
    if (op_abort === 1'b1) n_ab++;
    if (cycles == 20000) begin
      n_fail++;
      summarize();
    end
  end

  // -------------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------------
  task summarize();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // A frame, then time for the core side to settle.
  task run(input logic [63:0] v, input int nb, input int nr);
    h.xfer(v, nb, nr, rd);
    repeat (20) @(negedge clk);
  endtask

  // A hardware reset pulse of n cycles; 40 cycles after covers the recovery wait.
  task hw(input int n, input logic exp);
    int b;
    b = n_ab;
    hw_reset_b = 1'b0;
    repeat (n) @(negedge clk);
    chk("recovering", exp, recovering);
    hw_reset_b = 1'b1;
    repeat (40) @(negedge clk);
    chk("abort count", exp, n_ab - b);
  endtask

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    repeat (20) @(negedge clk);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    run({8'hAB, 56'h0}, 32, 16);
    chk("legacy id", {DEV, DEV}, rd[15:0]);
    run({8'h9F, 56'h0}, 8, 48);
    chk("std id", {MK, TC, MK, TC}, rd[47:0]);
    run({8'hAF, 56'h0}, 8, 24);
    chk("quad id in single mode", 0, h.oe_seen);
    for (a = 0; a < 2; a++) begin
      run({8'h90, 23'h0, a[0], 32'h0}, 32, 32);
      chk("maker dev", a ? {DEV, MK, DEV, MK} : {MK, DEV, MK, DEV}, rd[31:0]);
    end
    run({8'h4B, 56'h0}, 40, 136);
    chk("unique", {UID[119:0], UID[127:120]}, rd);
    run({8'h5A, 24'h10, 32'h0}, 40, 16);
    chk("param", {8'h10 ^ PK, 8'h11 ^ PK}, rd[15:0]);
    quad_command_mode = 1'b1;
    run({8'hAF, 56'h0}, 8, 24);
    chk("quad std id", {MK, TC}, rd[23:0]);
    run({8'h5A, 24'h10, 32'h0}, 40, 16);
    chk("param in quad", 0, h.oe_seen);
    quad_command_mode = 1'b0;
    $display("test ident done");
    prot_fail_set = 1'b1;
    prog_fail_set = 1'b1;
    erase_fail_set = 1'b1;
    @(negedge clk);
    {prot_fail_set, prog_fail_set, erase_fail_set} = 3'b000;
    run({8'h9F, 56'h0}, 8, 8);
    chk("flags held", 3'b111, {pf, gf, ef});
    run({8'h82, 56'h0}, 8, 0);
    chk("flags cleared", 3'b000, {pf, gf, ef});
    $display("test error flags done");
    for (a = 0; a < 2; a++) begin
      quad_command_mode = a[0];
      run({8'h66, 56'h0}, 8, 0);
      chk("armed", 1, reset_armed);
      run({8'h00, 56'h0}, 8, 0);
      chk("nop disarms", 0, reset_armed);
    end
    quad_command_mode = 1'b0;
    run({8'h66, 56'h0}, 8, 0);
    run({8'h9F, 56'h0}, 8, 8);
    chk("other disarms", 0, reset_armed);
    a = n_ab;
    run({8'h66, 56'h0}, 8, 0);
    run({8'h99, 56'h0}, 4, 0);
    chk("partial keeps arm", 1, reset_armed);
    chk("partial silent", 0, n_rl + h.oe_seen);
    run({8'h99, 56'h0}, 8, 0);
    chk("reload", 1, n_rl);
    chk("soft abort", 1, n_ab - a);
    $display("test soft reset done");
    hw(15, 1'b1);
    hw(8, 1'b0);
    quad_enable_bit = 1'b1;
    hw(15, 1'b0);
    dedicated_reset_en = 1'b1;
    hw(15, 1'b1);
    $display("test hardware reset done");
    summarize();
  end
endmodule

`default_nettype wire
